/* rtl/adsc_regs.svh */
// Purpose: offsets, fields, resets and counts of the converter control
// Assumes: 4-bit register address, 8-bit data
// Notes:   definitions only
`ifndef ADSC_REGS_SVH
`define ADSC_REGS_SVH

// register offsets
`define ADSC_OFF_CFG   4'h0
`define ADSC_OFF_SC2   4'h1
`define ADSC_OFF_SC1   4'h2
`define ADSC_OFF_RESH  4'h3
`define ADSC_OFF_RESL  4'h4
`define ADSC_OFF_CVH   4'h5
`define ADSC_OFF_CVL   4'h6
`define ADSC_OFF_PC1   4'h7
`define ADSC_OFF_PC2   4'h8

// reset values
`define ADSC_RST_CFG   8'h00
`define ADSC_RST_SC2   8'h00
`define ADSC_RST_SC1   8'h1F
`define ADSC_RST_BYTE  8'h00

// field codes
`define ADSC_CLK_BUS   2'h0
`define ADSC_CLK_HALF  2'h1
`define ADSC_MODE_10   2'h2
`define ADSC_CH_OFF    5'h1F
`define ADSC_FULL_10   10'h3FF
`define ADSC_FULL_8    10'h0FF
`define ADSC_ZERO      10'h000

// sample windows in conversion clocks, rounded up from 3.5 and 23.5
`define ADSC_SMP_SHORT 5'h04
`define ADSC_SMP_LONG  5'h18
// approximation steps per resolution
`define ADSC_STEP_10   5'h0A
`define ADSC_STEP_8    5'h08

`endif

/* rtl/adsc_pkg.sv */
// Purpose: types of the converter control
// Assumes: fields laid out from bit 7 down
// Notes:   register images travel as packed structs
package adsc_pkg;
    // configuration register image
    typedef struct packed {
        logic       low_power_select;
        logic [1:0] clock_divide_select;
        logic       long_sample_select;
        logic [1:0] mode_select;
        logic [1:0] input_clock_select;
    } adsc_cfg_t;
    // second status/control image (bit 7 is live state)
    typedef struct packed {
        logic       conversion_active_flag;
        logic       trigger_select;
        logic       compare_enable;
        logic       compare_direction_select;
        logic [3:0] reserved;
    } adsc_sc2_t;
    // first status/control image
    typedef struct packed {
        logic       conversion_complete_flag;
        logic       complete_interrupt_enable;
        logic       continuous_select;
        logic [4:0] channel_select;
    } adsc_sc1_t;
    // converter sequence
    typedef enum logic [1:0] {
        ADSC_IDLE,
        ADSC_SAMPLE,
        ADSC_CONVERT
    } adsc_state_t;
endpackage

/* rtl/adsc_ctrl.sv */
// Purpose: control, configuration and result logic of a 10-bit
//          successive-approximation converter
// Assumes: analog front end hands over a code and limit flags;
//          pins and trigger arrive from outside the mclk domain
// Notes:   registers reached over a plain strobe port
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "adsc_regs.svh"

//////////////////////////////////////////////////////////////////////
// What this block does
// - config bit 7 selects low power
// - config bits 6:5 divide input clock
// - config bit 4 selects long sample
// - config bits 3:2 select resolution, 10 is 10-bit
// - config bits 1:0 pick clock, 00 is bus
// - control two bit 7 shows conversion active
// - control two bit 6 picks hardware trigger
// - control two bits 5:4 compare enable, direction
// - control two bits 3:0 read zero
// - control one bit 7 read-only completion flag
// - control one bit 6 enables completion interrupt
// - control one bit 5 selects continuous conversions
// - control one bits 4:0 select channel
// - high byte read locks result until low read or control one write
// - pin bit disables digital function of pin
// - inputs beyond references clamp to scale ends
// - sample 4 or 24 conversion clocks (3.5, 23.5 rounded up)
// - compare gates completion flag by direction
// - deep stop returns every software register to reset
module adsc_ctrl
    import adsc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        deep_stop,
    input  wire logic        hw_trig,
    input  wire logic        alt_clk,
    input  wire logic [9:0]  ana_code,
    input  wire logic        ana_at_high,
    input  wire logic        ana_at_low,
    output logic      [4:0]  ana_channel,
    output logic             ana_sampling,
    output logic             ana_low_power,
    output logic      [15:0] pin_dig_disable,
    output logic             conv_irq
);

    //////////////////////////////////////////////////////////////////
    // state
    adsc_cfg_t   cfg_ff;            // configuration
    adsc_sc2_t   sc2_ff;            // control two (bits 3:0 unused)
    adsc_sc1_t   sc1_ff;            // control one
    logic [9:0]  res_ff;            // result word
    logic [1:0]  cvh_ff;            // compare value high bits
    logic [7:0]  cvl_ff;            // compare value low byte
    logic [7:0]  pc1_ff;            // pin control, first group
    logic [7:0]  pc2_ff;            // pin control, second group
    logic        lock_ff;           // result read in progress
    adsc_state_t st_ff;             // sequence state
    adsc_state_t nxt_st;            // next sequence state
    logic [4:0]  step_ff;           // clocks spent in state
    logic [2:0]  div_ff;            // divider count
    logic        half_ff;           // bus clock divided by two
    logic [9:0]  hold_ff;           // code caught at end of sample
    logic [9:0]  clamp;             // shaped code
    logic [7:0]  rdata_ff;          // read data, one cycle late
    logic        irq_ff;            // interrupt output
    logic        smp_ff;            // sampling output
    logic [12:0] meta_ff;           // first synchroniser stage
    logic [12:0] sync_ff;           // second synchroniser stage
    logic        alt_d_ff;          // alt clock, delayed
    logic        trg_d_ff;          // trigger, delayed

    //////////////////////////////////////////////////////////////////
    // bus decode
    wire wr_cfg  = reg_wr && (reg_addr == `ADSC_OFF_CFG);
    wire wr_sc2  = reg_wr && (reg_addr == `ADSC_OFF_SC2);
    wire wr_sc1  = reg_wr && (reg_addr == `ADSC_OFF_SC1);
    wire wr_cvh  = reg_wr && (reg_addr == `ADSC_OFF_CVH);
    wire wr_cvl  = reg_wr && (reg_addr == `ADSC_OFF_CVL);
    wire wr_pc1  = reg_wr && (reg_addr == `ADSC_OFF_PC1);
    wire wr_pc2  = reg_wr && (reg_addr == `ADSC_OFF_PC2);
    wire rd_resh = reg_rd && (reg_addr == `ADSC_OFF_RESH);
    wire rd_resl = reg_rd && (reg_addr == `ADSC_OFF_RESL);

    // written control one image
    adsc_sc1_t wr_img;
    assign wr_img = adsc_sc1_t'(reg_wdata);

    //////////////////////////////////////////////////////////////////
    // synchronised pins: {alt, trig, high, low, code}
    wire [12:0] pins_in = {alt_clk, hw_trig, ana_at_high,
                           ana_at_low, ana_code[8:0]};
    // code bit 9 rides a separate pair below
    logic       c9_meta_ff;         // code msb, first stage
    logic       c9_sync_ff;         // code msb, second stage

    wire        alt_s  = sync_ff[12];
    wire        trg_s  = sync_ff[11];
    wire        hi_s   = sync_ff[10];
    wire        lo_s   = sync_ff[9];
    wire [9:0]  code_s = {c9_sync_ff, sync_ff[8:0]};

    // two stages; only the second stage feeds logic
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff    <= 13'h0000;
            sync_ff    <= 13'h0000;
            c9_meta_ff <= 1'b0;
            c9_sync_ff <= 1'b0;
        end else begin
            meta_ff    <= pins_in;
            sync_ff    <= meta_ff;
            c9_meta_ff <= ana_code[9];
            c9_sync_ff <= c9_meta_ff;
        end
    end

    // edge memories for alt clock and trigger
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alt_d_ff <= 1'b0;
            trg_d_ff <= 1'b0;
        end else begin
            alt_d_ff <= alt_s;
            trg_d_ff <= trg_s;
        end
    end

    wire alt_edge = alt_s && !alt_d_ff;
    wire trg_edge = trg_s && !trg_d_ff;

    //////////////////////////////////////////////////////////////////
    // conversion clock as a tick of mclk
    // the asynchronous source is stood in by the alt pin, so both
    // upper codes use it; its rate is limited to mclk/2 by sampling
    wire src_tick =
        (cfg_ff.input_clock_select == `ADSC_CLK_BUS)  ? 1'b1 :
        (cfg_ff.input_clock_select == `ADSC_CLK_HALF) ? half_ff :
        alt_edge;
    wire [2:0] div_lim =
        3'((4'h1 << cfg_ff.clock_divide_select) - 4'h1);
    wire conversion_clock = src_tick && (div_ff == div_lim);

    // divider and half-rate toggle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff  <= 3'h0;
            half_ff <= 1'b0;
        end else if (deep_stop) begin
            div_ff  <= 3'h0;
            half_ff <= 1'b0;
        end else begin
            half_ff <= !half_ff;
            if (src_tick)
                div_ff <= conversion_clock ? 3'h0 : div_ff + 3'h1;
        end
    end

    //////////////////////////////////////////////////////////////////
    // sequence control
    wire is_10    = cfg_ff.mode_select == `ADSC_MODE_10;
    wire [4:0] smp_lim = cfg_ff.long_sample_select ?
        `ADSC_SMP_LONG : `ADSC_SMP_SHORT;
    wire [4:0] cnv_lim = is_10 ? `ADSC_STEP_10 : `ADSC_STEP_8;
    wire smp_end  = conversion_clock && (step_ff == smp_lim - 5'h01);
    wire cnv_end  = conversion_clock && (step_ff == cnv_lim - 5'h01);
    wire done     = (st_ff == ADSC_CONVERT) && cnv_end;

    // a write to control one restarts; software trigger starts
    wire sw_start = wr_sc1 && !sc2_ff.trigger_select &&
                    (wr_img.channel_select != `ADSC_CH_OFF);
    wire hw_start = trg_edge && sc2_ff.trigger_select &&
                    (st_ff == ADSC_IDLE) &&
                    (sc1_ff.channel_select != `ADSC_CH_OFF);

    // next state
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ADSC_IDLE: begin
                if (sw_start || hw_start)
                    nxt_st = ADSC_SAMPLE;
            end
            ADSC_SAMPLE: begin
                if (smp_end)
                    nxt_st = ADSC_CONVERT;
            end
            ADSC_CONVERT: begin
                if (cnv_end)
                    nxt_st = sc1_ff.continuous_select ?
                             ADSC_SAMPLE : ADSC_IDLE;
            end
        endcase
        // any write to control one aborts what runs
        if (wr_sc1)
            nxt_st = sw_start ? ADSC_SAMPLE : ADSC_IDLE;
        if (deep_stop)
            nxt_st = ADSC_IDLE;
    end

    // state, step count and caught code
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff   <= ADSC_IDLE;
            step_ff <= 5'h00;
            hold_ff <= `ADSC_ZERO;
        end else begin
            st_ff <= nxt_st;
            if (nxt_st != st_ff || wr_sc1)
                step_ff <= 5'h00;
            else if (conversion_clock)
                step_ff <= step_ff + 5'h01;
            if (st_ff == ADSC_SAMPLE && smp_end)
                hold_ff <= clamp;
        end
    end

    //////////////////////////////////////////////////////////////////
    // code shaping and compare
    // out-of-range inputs pin to the ends of the selected scale
    wire [9:0] full  = is_10 ? `ADSC_FULL_10 : `ADSC_FULL_8;
    wire [9:0] scale = is_10 ? code_s : {2'h0, code_s[9:2]};
    assign clamp = hi_s ? full :
                   lo_s ? `ADSC_ZERO : scale;

    wire [9:0] cmp_val = {cvh_ff, cvl_ff};
    wire       ge      = hold_ff >= cmp_val;
    wire       cmp_ok  = !sc2_ff.compare_enable ||
                         (sc2_ff.compare_direction_select ?
                          ge : !ge);
    // compare mode stores the difference, not the code
    wire [9:0] res_new = sc2_ff.compare_enable ?
                         hold_ff - cmp_val : hold_ff;
    // a locked result drops the new word and its flag
    wire xfer = done && cmp_ok && !lock_ff;

    //////////////////////////////////////////////////////////////////
    // result, lock and completion flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            res_ff  <= `ADSC_ZERO;
            lock_ff <= 1'b0;
        end else if (deep_stop) begin
            res_ff  <= `ADSC_ZERO;
            lock_ff <= 1'b0;
        end else begin
            if (xfer)
                res_ff <= res_new;
            // high byte locks, low byte or restart frees
            if (rd_resh)
                lock_ff <= 1'b1;
            else if (rd_resl || wr_sc1)
                lock_ff <= 1'b0;
        end
    end

    // flag: set wins over a control one write or low read in the same cycle
    wire nxt_conversion_complete_flag = xfer ? 1'b1 :
                    (wr_sc1 || rd_resl) ? 1'b0 :
                    sc1_ff.conversion_complete_flag;

    //////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= adsc_cfg_t'(`ADSC_RST_CFG);
            sc2_ff <= adsc_sc2_t'(`ADSC_RST_SC2);
            sc1_ff <= adsc_sc1_t'(`ADSC_RST_SC1);
        end else if (deep_stop) begin
            cfg_ff <= adsc_cfg_t'(`ADSC_RST_CFG);
            sc2_ff <= adsc_sc2_t'(`ADSC_RST_SC2);
            sc1_ff <= adsc_sc1_t'(`ADSC_RST_SC1);
        end else begin
            if (wr_cfg)
                cfg_ff <= adsc_cfg_t'(reg_wdata);
            if (wr_sc2) begin
                sc2_ff.trigger_select <= reg_wdata[6];
                sc2_ff.compare_enable <= reg_wdata[5];
                sc2_ff.compare_direction_select <= reg_wdata[4];
            end
            // active flag follows the sequence
            sc2_ff.conversion_active_flag <=
                (nxt_st != ADSC_IDLE);
            sc2_ff.reserved <= 4'h0;
            if (wr_sc1) begin
                sc1_ff.complete_interrupt_enable <= reg_wdata[6];
                sc1_ff.continuous_select <= reg_wdata[5];
                sc1_ff.channel_select <= reg_wdata[4:0];
            end
            sc1_ff.conversion_complete_flag <= nxt_conversion_complete_flag;
        end
    end

    // compare value and pin control bytes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cvh_ff <= 2'h0;
            cvl_ff <= `ADSC_RST_BYTE;
            pc1_ff <= `ADSC_RST_BYTE;
            pc2_ff <= `ADSC_RST_BYTE;
        end else if (deep_stop) begin
            cvh_ff <= 2'h0;
            cvl_ff <= `ADSC_RST_BYTE;
            pc1_ff <= `ADSC_RST_BYTE;
            pc2_ff <= `ADSC_RST_BYTE;
        end else begin
            if (wr_cvh)
                cvh_ff <= reg_wdata[1:0];
            if (wr_cvl)
                cvl_ff <= reg_wdata;
            if (wr_pc1)
                pc1_ff <= reg_wdata;
            if (wr_pc2)
                pc2_ff <= reg_wdata;
        end
    end

    //////////////////////////////////////////////////////////////////
    // read path: unmapped offsets answer zero
    wire [7:0] rd_mux =
        (reg_addr == `ADSC_OFF_CFG)  ? 8'(cfg_ff) :
        (reg_addr == `ADSC_OFF_SC2)  ? {8'(sc2_ff) & 8'hF0} :
        (reg_addr == `ADSC_OFF_SC1)  ? 8'(sc1_ff) :
        (reg_addr == `ADSC_OFF_RESH) ? {6'h00, res_ff[9:8]} :
        (reg_addr == `ADSC_OFF_RESL) ? res_ff[7:0] :
        (reg_addr == `ADSC_OFF_CVH)  ? {6'h00, cvh_ff} :
        (reg_addr == `ADSC_OFF_CVL)  ? cvl_ff :
        (reg_addr == `ADSC_OFF_PC1)  ? pc1_ff :
        (reg_addr == `ADSC_OFF_PC2)  ? pc2_ff : 8'h00;

    // read data stands one cycle, zero otherwise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end

    //////////////////////////////////////////////////////////////////
    // registered outputs toward front end and system
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
            smp_ff <= 1'b0;
        end else if (deep_stop) begin
            irq_ff <= 1'b0;
            smp_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_conversion_complete_flag &&
                      sc1_ff.complete_interrupt_enable;
            smp_ff <= (nxt_st == ADSC_SAMPLE);
        end
    end

    assign reg_rdata       = rdata_ff;
    assign conv_irq        = irq_ff;
    assign ana_sampling    = smp_ff;
    assign ana_channel     = sc1_ff.channel_select;
    assign ana_low_power   = cfg_ff.low_power_select;
    // set bit: buffer off, pullup off; conversion still allowed
    assign pin_dig_disable = {pc2_ff, pc1_ff};

endmodule

/* bench/adsc_ctrl_props.sv */
// Purpose: port-level checks of the converter control
// Assumes: one clock domain, bus clock undivided for window lengths
// Notes:   shadows track software writes; deep stop clears them
`timescale 1ns/1ps
`include "adsc_regs.svh"
module adsc_ctrl_props (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        deep_stop,
    input  wire logic [4:0]  ana_channel,
    input  wire logic        ana_sampling,
    input  wire logic        ana_low_power,
    input  wire logic [15:0] pin_dig_disable,
    input  wire logic        conv_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////
    // named decodes of the write and read strobes
    wire       wr_cfg = reg_wr && reg_addr == `ADSC_OFF_CFG;
    wire       wr_sc2 = reg_wr && reg_addr == `ADSC_OFF_SC2;
    wire       wr_sc1 = reg_wr && reg_addr == `ADSC_OFF_SC1;
    wire       rd_sc2 = reg_rd && reg_addr == `ADSC_OFF_SC2;
    logic [7:0] cfg_sh_ff;  // configuration as software wrote it
    logic       trig_sh_ff; // hardware trigger chosen
    logic       ien_sh_ff;  // completion interrupt enabled
    logic [5:0] smp_cnt_ff; // length of the running sample window
    // window length only known when the bus clock is used undivided
    wire       plain  = cfg_sh_ff[6:5] == 2'h0 && cfg_sh_ff[1:0] == 2'h0;
    wire [5:0] smp_len = cfg_sh_ff[4] ? 6'h18 : 6'h04;
    // shadows follow writes; deep stop behaves like reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b || deep_stop) begin
            cfg_sh_ff  <= 8'h00;
            trig_sh_ff <= 1'b0;
            ien_sh_ff  <= 1'b0;
        end else begin
            if (wr_cfg) cfg_sh_ff <= reg_wdata;
            if (wr_sc2) trig_sh_ff <= reg_wdata[6];
            if (wr_sc1) ien_sh_ff <= reg_wdata[6];
        end
    end
    // counts cycles with the sample output high
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) smp_cnt_ff <= 6'h00;
        else smp_cnt_ff <= ana_sampling ? smp_cnt_ff + 6'h01 : 6'h00;
    end
    ////////////////////////////////////////////////////////////////////
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_SC2_RSV: assert property (rd_sc2 |=> reg_rdata[3:0] == 4'h0)
        else $error("reserved control bits read nonzero");
    AST_ACTIVE: assert property (rd_sc2 && ana_sampling |=> reg_rdata[7])
        else $error("active flag low while sampling");
    AST_IRQ: assert property (conv_irq |-> $past(ien_sh_ff))
        else $error("interrupt raised while disabled");
    AST_CHAN: assert property (wr_sc1 && !deep_stop |=>
        ana_channel == $past(reg_wdata[4:0]))
        else $error("channel output does not follow write");
    AST_LOWPWR: assert property (wr_cfg && !deep_stop |=>
        ana_low_power == $past(reg_wdata[7]))
        else $error("low power output does not follow write");
    AST_PINS: assert property (reg_wr && reg_addr == `ADSC_OFF_PC1
        && !deep_stop |=> pin_dig_disable[7:0] == $past(reg_wdata))
        else $error("pin disable does not follow write");
    AST_DEEP: assert property (deep_stop |=> ana_channel == `ADSC_CH_OFF
        && !ana_sampling && !conv_irq && pin_dig_disable == 16'h0000)
        else $error("deep stop left state behind");
    AST_SMP_LEN: assert property ($fell(ana_sampling) && plain
        && !$past(wr_sc1) && !$past(deep_stop) |-> smp_cnt_ff == smp_len)
        else $error("sample window length wrong");
    AST_START: assert property (wr_sc1 && !deep_stop
        && reg_wdata[4:0] != `ADSC_CH_OFF |=> ana_sampling == !trig_sh_ff)
        else $error("software start misbehaves");
    // main scenarios reached
    cover property ($fell(ana_sampling) && cfg_sh_ff[4]);
    cover property ($rose(conv_irq));
    cover property (deep_stop);
endmodule

bind adsc_ctrl adsc_ctrl_props u_props (.mclk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .deep_stop, .ana_channel,
    .ana_sampling, .ana_low_power, .pin_dig_disable, .conv_irq);

/* bench/adsc_afe_model.sv */
// Purpose: analog front end behind the shared input pins
// Assumes: only analog_input_one carries a bench-set level
// Notes:   no channel chosen means a code that never settles
`timescale 1ns/1ps
module adsc_afe_model (
    input  wire logic       mclk,
    input  wire logic [4:0] ana_channel,
    input  wire logic [9:0] lvl,
    input  wire logic       hi,
    input  wire logic       lo,
    output logic      [9:0] ana_code,
    output logic            ana_at_high,
    output logic            ana_at_low
);
    logic [9:0] junk_ff = 10'h000; // walks so a stale code is never held
    wire        one = ana_channel == 5'h01; // analog_input_one chosen
    // junk pattern runs every cycle
    always_ff @(posedge mclk) junk_ff <= junk_ff + 10'h155;
    // code follows the level; beyond the references it is left raw
    assign ana_code = one ? lvl :
        ana_channel == 5'h1F ? junk_ff : {ana_channel, ana_channel};
    assign ana_at_high = one & hi;
    assign ana_at_low  = one & lo;
endmodule

/* bench/testbench.sv */
// Purpose: register-level test of the converter control
// Assumes: bus clock 100 MHz, alternate clock at half rate
// Notes:   each access takes two cycles, strobes never overlap
`timescale 1ns/1ps
`include "adsc_regs.svh"
module testbench;
    logic        mclk, rst_b, reg_wr, reg_rd, deep_stop, hw_trig, alt_clk;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [9:0]  ana_code, lvl;
    logic        ana_at_high, ana_at_low, hi, lo;
    logic [4:0]  ana_channel;
    logic        ana_sampling, ana_low_power, conv_irq;
    logic [15:0] pin_dig_disable;
    int          mismatches, comparisons, cycles;
    logic [7:0]  cfgs [10] = '{8'h98, 8'h08, 8'h18, 8'h28, 8'h48, 8'h68,
                              8'h09, 8'h0A, 8'h0B, 8'h00};
    adsc_ctrl u_dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .deep_stop, .hw_trig, .alt_clk, .ana_code,
        .ana_at_high, .ana_at_low, .ana_channel, .ana_sampling,
        .ana_low_power, .pin_dig_disable, .conv_irq);
    adsc_afe_model u_afe (.mclk, .ana_channel, .lvl, .hi, .lo, .ana_code,
        .ana_at_high, .ana_at_low);
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // write: one strobe cycle, then one idle cycle
    task automatic wr(logic [3:0] a, logic [7:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0; @(posedge mclk);
    endtask
    // read data taken just after the edge that answers
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk); reg_rd <= 1'b0; #1 d = reg_rdata; @(posedge mclk);
    endtask
    task automatic rdchk(string n, logic [3:0] a, logic [7:0] e);
        logic [7:0] d;
        rd(a, d); chk(n, d, e);
    endtask
    // polls the completion flag a bounded number of times
    task automatic wait_conversion_complete_flag(int lim, output logic f);
        logic [7:0] d;
        f = 1'b0;
        repeat (lim) if (!f) begin
            rd(`ADSC_OFF_SC1, d); f = d[7];
        end
    endtask
    // software conversion on analog_input_one, result checked
    task automatic convert(logic [7:0] s1, logic [9:0] e);
        logic [7:0] d, h;
        logic f;
        wr(`ADSC_OFF_SC1, s1);
        chk("channel", ana_channel, 5'h01);
        rd(`ADSC_OFF_SC2, d); chk("active", d[7], 1'b1);
        wait_conversion_complete_flag(100, f); chk("complete", f, 1'b1);
        chk("irq", conv_irq, s1[6]);
        rd(`ADSC_OFF_RESH, h); rd(`ADSC_OFF_RESL, d);
        chk("result", {h[1:0], d}, e);
        rdchk("flag cleared", `ADSC_OFF_SC1, {1'b0, s1[6:0]});
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // alternate source: one rising edge every two bus clocks
    always @(posedge mclk) alt_clk <= rst_b && !alt_clk;
    // hang guard, far above the thousand or so cycles needed
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        logic [7:0] d;
        logic f;
        rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
        reg_wdata = 8'h00; deep_stop = 1'b0; hw_trig = 1'b0;
        lvl = 10'h2AA; hi = 1'b0; lo = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1; @(posedge mclk);
        rdchk("cfg reset", `ADSC_OFF_CFG, `ADSC_RST_CFG);
        rdchk("sc2 reset", `ADSC_OFF_SC2, `ADSC_RST_SC2);
        rdchk("sc1 reset", `ADSC_OFF_SC1, `ADSC_RST_SC1);
        wr(4'h9, 8'hFF); rdchk("unmapped", 4'h9, 8'h00);
        wr(`ADSC_OFF_SC2, 8'h7C); rdchk("sc2", `ADSC_OFF_SC2, 8'h70);
        wr(`ADSC_OFF_SC1, 8'h9F); rdchk("sc1", `ADSC_OFF_SC1, 8'h1F);
        // every clock, divide and sample setting and modes 10 and 00, in set-up order
        for (int i = 0; i < 10; i++) begin
            wr(`ADSC_OFF_CFG, cfgs[i]); wr(`ADSC_OFF_SC2, 8'h00);
            chk("low power", ana_low_power, cfgs[i][7]);
            rdchk("cfg", `ADSC_OFF_CFG, cfgs[i]);
            convert(8'h41, cfgs[i][3:2] == 2'h2 ? lvl :
                {2'h0, lvl[9:2]});
        end
        // clamping at both references and both resolutions
        for (int i = 0; i < 3; i++) begin
            hi <= (i < 2); lo <= (i == 2);
            wr(`ADSC_OFF_CFG, i == 1 ? 8'h00 : 8'h08);
            convert(8'h01, i == 0 ? `ADSC_FULL_10 :
                i == 1 ? `ADSC_FULL_8 : `ADSC_ZERO);
        end
        hi <= 1'b0; lo <= 1'b0; lvl <= 10'h180;
        wr(`ADSC_OFF_CVH, 8'h01); wr(`ADSC_OFF_CVL, 8'h00);
        wr(`ADSC_OFF_SC2, 8'h30); convert(8'h01, 10'h080);
        wr(`ADSC_OFF_SC2, 8'h20); wr(`ADSC_OFF_SC1, 8'h01);
        wait_conversion_complete_flag(40, f); chk("compare miss", f, 1'b0);
        lvl <= 10'h0C0; convert(8'h01, 10'h3C0);
        // continuous run with the result locked by a high read
        wr(`ADSC_OFF_SC2, 8'h00); lvl <= 10'h155;
        wr(`ADSC_OFF_SC1, 8'h21); wait_conversion_complete_flag(40, f); lvl <= 10'h2AA;
        rdchk("locked high", `ADSC_OFF_RESH, 8'h01);
        repeat (40) @(posedge mclk);
        rdchk("locked low", `ADSC_OFF_RESL, 8'h55);
        wait_conversion_complete_flag(40, f); chk("continuous", f, 1'b1);
        wr(`ADSC_OFF_SC1, 8'h1F);
        rdchk("write clears", `ADSC_OFF_SC1, 8'h1F);
        rdchk("next high", `ADSC_OFF_RESH, 8'h02);
        rdchk("next low", `ADSC_OFF_RESL, 8'hAA);
        // hardware trigger: the write only arms
        wr(`ADSC_OFF_SC2, 8'h40); wr(`ADSC_OFF_SC1, 8'h01);
        chk("armed", ana_sampling, 1'b0);
        hw_trig <= 1'b1; repeat (4) @(posedge mclk); hw_trig <= 1'b0;
        wait_conversion_complete_flag(40, f); chk("hw trigger", f, 1'b1);
        chk("irq off", conv_irq, 1'b0);
        wr(`ADSC_OFF_PC1, 8'h02); wr(`ADSC_OFF_PC2, 8'h80);
        chk("pins", pin_dig_disable, 16'h8002);
        wr(`ADSC_OFF_CFG, 8'h98);
        deep_stop <= 1'b1; @(posedge mclk);
        deep_stop <= 1'b0; @(posedge mclk);
        chk("deep pins", pin_dig_disable, 16'h0000);
        rdchk("deep cfg", `ADSC_OFF_CFG, 8'h00);
        rdchk("deep sc1", `ADSC_OFF_SC1, 8'h1F);
        finish_test;
    end
endmodule
